// File: core/mhc_top.sv
// maintenance hours counter: operating time and time-to-go
`timescale 1ns/1ps
`include "mhc_regs.svh"
// How it works
// - partial reset rise clears output, reloads time-to-go from interval
// - partial reset leaves operating time untouched
// - full reset rise: output 0, operating time 0, time-to-go = interval
// - monitor high outside programming mode advances operating time and reduces time-to-go, else hold
// - output goes high once time-to-go is zero
// - reset-only mode clears output while either reset input is high
// - reset-or-idle mode also clears output while monitor is low
// - operating time counts while monitoring regardless of partial reset
// - operating time saturates at 99999 hours
// - interval set in hours 0..9999 and minutes 0..59
// - operating time offset loadable only in programming mode
// - after offset load time-to-go = interval minus (time mod interval)
// - runtime interval change loads time-to-go with the new interval
// - time-to-go and operating time are restored from retained values at power-up; interval is not
// - interval may come from another block's live actual value
module mhc_top
   import mhc_pkg::*;
#(
   parameter int MINUTE_CYC = `MHC_MINUTE_S * `MHC_CLK_HZ,
   parameter int OT_W       = `MHC_OT_W,
   parameter int TTG_W      = `MHC_TTG_W
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             monitor_i,
   input  wire logic             part_reset_i,
   input  wire logic             full_reset_i,
   input  wire logic             clr_on_idle_i,
   input  wire logic [13:0]      mi_hours_i,
   input  wire logic [5:0]       mi_mins_i,
   input  wire logic             mi_from_block_i,
   input  wire logic [15:0]      block_value_i,
   input  wire logic             prog_mode_i,
   input  wire logic             ot_offset_load_i,
   input  wire logic [16:0]      ot_offset_hours_i,
   input  wire logic [5:0]       ot_offset_mins_i,
   input  wire logic [OT_W-1:0]  nv_operating_time_i,
   input  wire logic [TTG_W-1:0] nv_time_to_go_i,
   output logic                  q_o,
   output logic [OT_W-1:0]       operating_time_o,
   output logic [TTG_W-1:0]      time_to_go_o,
   output logic [TTG_W-1:0]      maintenance_interval_o,
   output logic                  ot_limit_o,
   output logic                  recompute_busy_o
);

   // ------------------------------------------------------------
   // constants
   // ------------------------------------------------------------
   localparam int OT_MAX_MIN = `MHC_OT_HOURS_MAX * `MHC_MIN_PER_HOUR;
   localparam int OT_TOP_MIN = OT_MAX_MIN + `MHC_MINS_MAX;
   localparam int MI_TOP_MIN =
      `MHC_MI_HOURS_MAX * `MHC_MIN_PER_HOUR + `MHC_MINS_MAX;

   if (MINUTE_CYC < 1 || MINUTE_CYC >= (1 << `MHC_PRESC_W))
      $error("mhc_top: minute prescale out of range");
   if (OT_W < 23 || OT_W > 30 || OT_TOP_MIN >= (1 << OT_W))
      $error("mhc_top: operating time width too small");
   if (TTG_W < 20 || TTG_W > 30 || MI_TOP_MIN >= (1 << TTG_W))
      $error("mhc_top: time-to-go width too small");

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                    rst_meta_r;
   logic                    rst_sync_r;
   logic                    rst_n;
   logic                    restore_r;
   logic                    part_d_r;
   logic                    full_d_r;
   logic                    load_d_r;
   logic                    part_rise;
   logic                    full_rise;
   logic                    load_rise;
   logic [`MHC_PRESC_W-1:0] presc_r;
   logic                    counting;
   logic                    minute_tick;
   logic [16:0]             mi_src_hours;
   logic [16:0]             mi_cl_hours;
   logic [5:0]              mi_cl_mins;
   logic [TTG_W-1:0]        mi_eff;
   logic [TTG_W-1:0]        mi_last_r;
   logic                    mi_changed;
   logic [16:0]             off_cl_hours;
   logic [5:0]              off_cl_mins;
   logic [OT_W-1:0]         off_min;
   logic [OT_W-1:0]         ot_r;
   logic [TTG_W-1:0]        ttg_r;
   logic                    ot_at_limit;
   logic                    clr_out;
   mhc_clr_mode_t           clr_mode;
   logic                    rem_start;
   logic                    rem_busy;
   logic                    rem_done;
   logic [TTG_W-1:0]        rem_val;

   // ------------------------------------------------------------
   // reset release through two flip-flops
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_r <= 1'h0;
         rst_sync_r <= 1'h0;
      end else begin
         rst_meta_r <= 1'h1;
         rst_sync_r <= rst_meta_r;
      end
   end

   assign rst_n = rst_sync_r;

   // ------------------------------------------------------------
   // restore of retained values after power-up
   // ------------------------------------------------------------
   // one cycle after release the backed-up values are taken back
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         restore_r <= 1'h1;
      end else begin
         restore_r <= 1'h0;
      end
   end

   // ------------------------------------------------------------
   // edge detection of reset and load inputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         part_d_r <= `MHC_ZERO_RST;
         full_d_r <= `MHC_ZERO_RST;
         load_d_r <= `MHC_ZERO_RST;
      end else begin
         part_d_r <= part_reset_i;
         full_d_r <= full_reset_i;
         load_d_r <= ot_offset_load_i;
      end
   end

   assign part_rise = part_reset_i & ~part_d_r;
   assign full_rise = full_reset_i & ~full_d_r;
   // offset only accepted in programming mode
   assign load_rise = ot_offset_load_i & ~load_d_r & prog_mode_i;

   // ------------------------------------------------------------
   // minute time base
   // ------------------------------------------------------------
   // counting only in run mode while the monitor input is high
   assign counting = monitor_i & ~prog_mode_i & ~restore_r;
   assign minute_tick =
      counting && (presc_r == `MHC_PRESC_W'(MINUTE_CYC - 1));

   // partial minute held while idle, so short runs add up
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         presc_r <= '0;
      end else if (full_rise) begin
         presc_r <= '0;
      end else if (minute_tick) begin
         presc_r <= '0;
      end else if (counting) begin
         presc_r <= presc_r + `MHC_PRESC_W'(1);
      end
   end

   // ------------------------------------------------------------
   // effective maintenance interval in minutes
   // ------------------------------------------------------------
   // live value of another block, taken as hours
   assign mi_src_hours = mi_from_block_i ? {1'h0, block_value_i}
                                         : {3'h0, mi_hours_i};
   // out of range values round to the nearest valid one
   assign mi_cl_hours = (mi_src_hours > 17'(`MHC_MI_HOURS_MAX))
                      ? 17'(`MHC_MI_HOURS_MAX) : mi_src_hours;
   assign mi_cl_mins  = mi_from_block_i ? 6'h00
                      : (mi_mins_i > 6'(`MHC_MINS_MAX))
                      ? 6'(`MHC_MINS_MAX) : mi_mins_i;
   // widen before the product: 9999 h in minutes needs 20 bits
   assign mi_eff = TTG_W'(mi_cl_hours) * TTG_W'(`MHC_MIN_PER_HOUR)
                 + TTG_W'(mi_cl_mins);

   // interval tracker for runtime change detection
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mi_last_r <= '0;
      end else begin
         mi_last_r <= mi_eff;
      end
   end

   assign mi_changed = (mi_eff != mi_last_r) & ~prog_mode_i & ~restore_r;

   // ------------------------------------------------------------
   // operating time offset in minutes
   // ------------------------------------------------------------
   assign off_cl_hours = (ot_offset_hours_i > 17'(`MHC_OT_HOURS_MAX))
                       ? 17'(`MHC_OT_HOURS_MAX) : ot_offset_hours_i;
   assign off_cl_mins  = (ot_offset_mins_i > 6'(`MHC_MINS_MAX))
                       ? 6'(`MHC_MINS_MAX) : ot_offset_mins_i;
   assign off_min = OT_W'(off_cl_hours) * OT_W'(`MHC_MIN_PER_HOUR)
                  + OT_W'(off_cl_mins);

   // ------------------------------------------------------------
   // accumulated operating time
   // ------------------------------------------------------------
   assign ot_at_limit = (ot_r >= OT_W'(OT_MAX_MIN));

   // retained value: power-up restore, cleared only by full reset
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ot_r <= '0;
      end else if (restore_r) begin
         ot_r <= nv_operating_time_i;
      end else if (full_rise) begin
         ot_r <= '0;
      end else if (load_rise) begin
         ot_r <= off_min;
      end else if (minute_tick && !ot_at_limit) begin
         // partial reset plays no part here
         ot_r <= ot_r + OT_W'(1);
      end
   end

   // ------------------------------------------------------------
   // remainder of offset over interval
   // ------------------------------------------------------------
   assign rem_start = load_rise;

   mhc_rem #(
      .DW (OT_W),
      .VW (TTG_W)
   ) u_rem (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n),
      .start_i    (rem_start),
      .dividend_i (off_min),
      .divisor_i  (mi_eff),
      .busy_o     (rem_busy),
      .done_o     (rem_done),
      .rem_o      (rem_val)
   );

   // ------------------------------------------------------------
   // time-to-go
   // ------------------------------------------------------------
   // resets win over a finishing recompute and over counting
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ttg_r <= '0;
      end else if (restore_r) begin
         ttg_r <= nv_time_to_go_i;
      end else if (full_rise || part_rise) begin
         ttg_r <= mi_eff;
      end else if (rem_done) begin
         ttg_r <= mi_eff - rem_val;
      end else if (mi_changed) begin
         ttg_r <= mi_eff;
      end else if (minute_tick && ttg_r != '0) begin
         ttg_r <= ttg_r - TTG_W'(1);
      end
   end

   // ------------------------------------------------------------
   // output
   // ------------------------------------------------------------
   assign clr_mode = clr_on_idle_i ? MHC_CLR_RESET_OR_IDLE
                                   : MHC_CLR_RESET_ONLY;

   // clear conditions take priority over the set condition
   always_comb begin
      clr_out = part_reset_i | full_reset_i;
      case (clr_mode)
         MHC_CLR_RESET_OR_IDLE: clr_out = clr_out | ~monitor_i;
         MHC_CLR_RESET_ONLY:    clr_out = clr_out;
         default:               clr_out = 1'h1;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q_o <= 1'h0;
      end else if (restore_r) begin
         q_o <= 1'h0;
      end else begin
         q_o <= ~clr_out & (ttg_r == '0);
      end
   end

   // ------------------------------------------------------------
   // visible state
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ot_limit_o       <= 1'h0;
         recompute_busy_o <= 1'h0;
      end else begin
         ot_limit_o       <= ot_at_limit;
         recompute_busy_o <= rem_busy | rem_start;
      end
   end

   assign operating_time_o       = ot_r;
   assign time_to_go_o           = ttg_r;
   assign maintenance_interval_o = mi_last_r;

endmodule

// File: core/mhc_regs.svh
// constants of the maintenance hours counter
`ifndef MHC_REGS_SVH
`define MHC_REGS_SVH

// -----------------------------------------------------------------
// time base
// -----------------------------------------------------------------
`define MHC_CLK_HZ        10000000
`define MHC_MINUTE_S      60

// -----------------------------------------------------------------
// value ranges
// -----------------------------------------------------------------
`define MHC_MIN_PER_HOUR  60
`define MHC_MINS_MAX      59
`define MHC_MI_HOURS_MAX  9999
`define MHC_OT_HOURS_MAX  99999

// -----------------------------------------------------------------
// default widths and reset values
// -----------------------------------------------------------------
`define MHC_OT_W          23
`define MHC_TTG_W         20
`define MHC_PRESC_W       30
`define MHC_ZERO_RST      1'h0

`endif

// File: core/mhc_pkg.sv
// types of the maintenance hours counter
package mhc_pkg;

   // state of the remainder unit
   typedef enum logic [0:0] {
      MHC_REM_IDLE,
      MHC_REM_RUN
   } mhc_rem_state_t;

   // output clear mode
   typedef enum logic [0:0] {
      MHC_CLR_RESET_ONLY,
      MHC_CLR_RESET_OR_IDLE
   } mhc_clr_mode_t;

endpackage

// File: core/mhc_rem.sv
// sequential remainder unit: dividend modulo divisor
`timescale 1ns/1ps
module mhc_rem
   import mhc_pkg::*;
#(
   parameter int DW = 23,
   parameter int VW = 20
) (
   input  wire logic          sys_clk_i,
   input  wire logic          rst_n_i,
   input  wire logic          start_i,
   input  wire logic [DW-1:0] dividend_i,
   input  wire logic [VW-1:0] divisor_i,
   output logic               busy_o,
   output logic               done_o,
   output logic [VW-1:0]      rem_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   mhc_rem_state_t  state_r;
   logic [DW-1:0]   dvd_r;
   logic [VW-1:0]   dvs_r;
   logic [VW:0]     acc_r;
   logic [VW:0]     acc_sh;
   logic [5:0]      cnt_r;

   if (DW < 2 || DW > 63 || VW < 1)
      $error("mhc_rem: unsupported widths");

   // shift in the next dividend bit
   assign acc_sh = {acc_r[VW-1:0], dvd_r[DW-1]};
   assign busy_o = (state_r == MHC_REM_RUN);

   // restoring division, one dividend bit per cycle
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= MHC_REM_IDLE;
         dvd_r   <= '0;
         dvs_r   <= '0;
         acc_r   <= '0;
         cnt_r   <= '0;
         done_o  <= 1'h0;
         rem_o   <= '0;
      end else begin
         done_o <= 1'h0;
         case (state_r)
            MHC_REM_IDLE: begin
               if (start_i) begin
                  dvd_r   <= dividend_i;
                  dvs_r   <= divisor_i;
                  acc_r   <= '0;
                  cnt_r   <= 6'(DW);
                  state_r <= MHC_REM_RUN;
               end
            end
            MHC_REM_RUN: begin
               if (acc_sh >= {1'h0, dvs_r} && dvs_r != '0) begin
                  acc_r <= acc_sh - {1'h0, dvs_r};
               end else begin
                  acc_r <= acc_sh;
               end
               dvd_r <= {dvd_r[DW-2:0], 1'h0};
               cnt_r <= cnt_r - 6'h01;
               if (cnt_r == 6'h01) begin
                  state_r <= MHC_REM_IDLE;
                  done_o  <= 1'h1;
                  // zero interval gives zero remainder
                  if (dvs_r == '0) begin
                     rem_o <= '0;
                  end else if (acc_sh >= {1'h0, dvs_r}) begin
                     rem_o <= VW'(acc_sh - {1'h0, dvs_r});
                  end else begin
                     rem_o <= acc_sh[VW-1:0];
                  end
               end
            end
            default: state_r <= MHC_REM_IDLE;
         endcase
      end
   end

endmodule

// File: verif/mhc_top_chk.sv
// assertion checker for the maintenance hours counter
`timescale 1ns/1ps
module mhc_top_chk
   import mhc_pkg::*;
#(
   parameter int MINUTE_CYC = 10,
   parameter int OT_W       = 23,
   parameter int TTG_W      = 20
) (
   input wire logic             sys_clk_i,
   input wire logic             rst_b_i,
   input wire logic             monitor_i,
   input wire logic             part_reset_i,
   input wire logic             full_reset_i,
   input wire logic             clr_on_idle_i,
   input wire logic             prog_mode_i,
   input wire logic             ot_offset_load_i,
   input wire logic             q_o,
   input wire logic [OT_W-1:0]  operating_time_o,
   input wire logic [TTG_W-1:0] time_to_go_o,
   input wire logic [TTG_W-1:0] maintenance_interval_o,
   input wire logic             ot_limit_o,
   input wire logic             recompute_busy_o
);
   logic [2:0] live_cnt_r;
   logic       live;

   // ----------------------------------------------------------
   // settle window: skip release, restore and first past value
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         live_cnt_r <= 3'h0;
      end else if (live_cnt_r != 3'h5) begin
         live_cnt_r <= live_cnt_r + 3'h1;
      end
   end
   assign live = (live_cnt_r >= 3'h4);

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i || !live);

   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   a_part_reload: assert property (
      $rose(part_reset_i) && !full_reset_i |=>
      time_to_go_o == maintenance_interval_o && !q_o)
      else $error("partial reset did not reload time to go");
   a_full_clears: assert property (
      $rose(full_reset_i) |=> operating_time_o == '0 &&
      time_to_go_o == maintenance_interval_o && !q_o)
      else $error("full reset did not clear the counters");
   a_reset_clr_q: assert property (
      part_reset_i || full_reset_i |=> !q_o)
      else $error("output high while a reset input is high");
   a_idle_clr_q: assert property (
      clr_on_idle_i && !monitor_i |=> !q_o)
      else $error("output high while idle in idle clear mode");
   a_zero_sets_q: assert property (
      time_to_go_o == '0 && !part_reset_i && !full_reset_i &&
      !prog_mode_i && !recompute_busy_o &&
      (monitor_i || !clr_on_idle_i) |=> q_o)
      else $error("output low with time to go at zero");
   a_q_needs_zero: assert property (
      $rose(q_o) |-> $past(time_to_go_o) == '0)
      else $error("output rose with time to go not zero");
   a_ot_idle_hold: assert property (
      !monitor_i && !full_reset_i && !ot_offset_load_i |=>
      $stable(operating_time_o))
      else $error("operating time moved while idle");
   a_ot_one_step: assert property (
      monitor_i && !full_reset_i && !ot_offset_load_i |=>
      operating_time_o - $past(operating_time_o) <= 1)
      else $error("operating time stepped by more than one");
   a_ot_saturate: assert property (
      ot_limit_o && !full_reset_i && !ot_offset_load_i |=>
      $stable(operating_time_o))
      else $error("operating time moved past its limit");
endmodule

bind mhc_top mhc_top_chk #(
   .MINUTE_CYC(MINUTE_CYC),
   .OT_W      (OT_W),
   .TTG_W     (TTG_W)
) mhc_top_chk_i (
   .sys_clk_i             (sys_clk_i),
   .rst_b_i               (rst_b_i),
   .monitor_i             (monitor_i),
   .part_reset_i          (part_reset_i),
   .full_reset_i          (full_reset_i),
   .clr_on_idle_i         (clr_on_idle_i),
   .prog_mode_i           (prog_mode_i),
   .ot_offset_load_i      (ot_offset_load_i),
   .q_o                   (q_o),
   .operating_time_o      (operating_time_o),
   .time_to_go_o          (time_to_go_o),
   .maintenance_interval_o(maintenance_interval_o),
   .ot_limit_o            (ot_limit_o),
   .recompute_busy_o      (recompute_busy_o)
);

// File: verif/mhc_prog_model.sv
// model of the program logic driving monitor and reset inputs
`timescale 1ns/1ps
module mhc_prog_model #(
   parameter int MINUTE_CYC = 10
) (
   input  wire logic sys_clk_i,
   output logic      monitor_o,
   output logic      part_reset_o,
   output logic      full_reset_o
);
   // all lines idle low at start
   initial begin
      monitor_o = 1'h0;
      part_reset_o = 1'h0;
      full_reset_o = 1'h0;
   end

   // whole minutes of monitoring keep the prescaler phase aligned
   task automatic run_minutes(input int n, input logic hold_r);
      @(negedge sys_clk_i);
      monitor_o = 1'h1;
      part_reset_o = hold_r;
      repeat (n * MINUTE_CYC) @(negedge sys_clk_i);
      monitor_o = 1'h0;
      part_reset_o = 1'h0;
   endtask

   // one reset input held high for len cycles
   task automatic pulse_reset(input logic full, input int len);
      @(negedge sys_clk_i);
      if (full) begin
         full_reset_o = 1'h1;
      end else begin
         part_reset_o = 1'h1;
      end
      repeat (len) @(negedge sys_clk_i);
      full_reset_o = 1'h0;
      part_reset_o = 1'h0;
   endtask
endmodule

// File: verif/test_maintenance_hours_counter.sv
// self-checking bench of the maintenance hours counter
`timescale 1ns/1ps
module test_maintenance_hours_counter;
   localparam int MCYC = 10;
   logic        sys_clk, rst_b, clr_idle, from_blk, prog, ld;
   logic        q, ot_lim, busy, mon, part_r, full_r;
   logic [13:0] mi_h;
   logic [5:0]  mi_m, off_m;
   logic [15:0] blk;
   logic [16:0] off_h;
   logic [22:0] nv_ot, ot;
   logic [19:0] nv_ttg, ttg, mi;
   int          n_fail, checked, n_cyc, i;

   mhc_prog_model #(.MINUTE_CYC(MCYC)) mhc_prog_model_i (
      .sys_clk_i(sys_clk), .monitor_o(mon),
      .part_reset_o(part_r), .full_reset_o(full_r));

   mhc_top #(.MINUTE_CYC(MCYC)) mhc_top_i (
      .sys_clk_i(sys_clk), .rst_b_i(rst_b), .monitor_i(mon),
      .part_reset_i(part_r), .full_reset_i(full_r),
      .clr_on_idle_i(clr_idle), .mi_hours_i(mi_h), .mi_mins_i(mi_m),
      .mi_from_block_i(from_blk), .block_value_i(blk),
      .prog_mode_i(prog), .ot_offset_load_i(ld),
      .ot_offset_hours_i(off_h), .ot_offset_mins_i(off_m),
      .nv_operating_time_i(nv_ot), .nv_time_to_go_i(nv_ttg),
      .q_o(q), .operating_time_o(ot), .time_to_go_o(ttg),
      .maintenance_interval_o(mi), .ot_limit_o(ot_lim),
      .recompute_busy_o(busy));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic chk(input logic [22:0] got, input logic [22:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic complete_run;
      $display("checks=%0d failures=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // offset load strobe for one cycle
   task automatic load_pulse;
      ld = 1'h1;
      cyc(1);
      ld = 1'h0;
   endtask

   // clock and hang guard
   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      n_cyc = n_cyc + 1;
      if (n_cyc == 3000) begin
         n_fail = n_fail + 1;
         complete_run;
      end
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      n_fail = 0;
      checked = 0;
      n_cyc = 0;
      rst_b = 1'h0;
      clr_idle = 1'h0;
      from_blk = 1'h0;
      prog = 1'h0;
      ld = 1'h0;
      mi_h = 14'h0;
      mi_m = 6'h5;
      blk = 16'h0;
      off_h = 17'h0;
      off_m = 6'h0;
      nv_ot = 23'h5;
      nv_ttg = 20'h3;
      cyc(6);
      rst_b = 1'h1;
      cyc(6);
      chk(ot, 23'h5);
      chk(ttg, 23'h3);
      chk(mi, 23'h5);
      mhc_prog_model_i.run_minutes(3, 1'h0);
      cyc(3);
      chk(ot, 23'h8);
      chk(ttg, 23'h0);
      chk(q, 23'h1);
      mhc_prog_model_i.run_minutes(1, 1'h0);
      cyc(3);
      chk(ot, 23'h9);
      chk(ttg, 23'h0);
      chk(q, 23'h1);
      clr_idle = 1'h1;
      cyc(3);
      chk(q, 23'h0);
      clr_idle = 1'h0;
      cyc(3);
      chk(q, 23'h1);
      mhc_prog_model_i.pulse_reset(1'h0, 2);
      cyc(3);
      chk(ttg, 23'h5);
      chk(ot, 23'h9);
      chk(q, 23'h0);
      mhc_prog_model_i.run_minutes(1, 1'h1);
      cyc(3);
      chk(ot, 23'hA);
      mi_m = 6'h7;
      cyc(4);
      chk(ttg, 23'h7);
      chk(mi, 23'h7);
      mhc_prog_model_i.pulse_reset(1'h1, 3);
      cyc(3);
      chk(ot, 23'h0);
      chk(ttg, 23'h7);
      chk(q, 23'h0);
      prog = 1'h1;
      off_h = 17'h1869E;
      off_m = 6'h3B;
      cyc(2);
      load_pulse();
      for (i = 0; i < 40 && busy !== 1'h0; i++) cyc(1);
      chk(busy, 23'h0);
      chk(ot, 23'h5B8D43);
      chk(ttg, 23'h6);
      prog = 1'h0;
      off_h = 17'h1;
      cyc(2);
      load_pulse();
      cyc(3);
      chk(ot, 23'h5B8D43);
      mhc_prog_model_i.run_minutes(1, 1'h0);
      cyc(3);
      chk(ot, 23'h5B8D44);
      chk(ttg, 23'h5);
      chk(ot_lim, 23'h1);
      mhc_prog_model_i.run_minutes(1, 1'h0);
      cyc(3);
      chk(ot, 23'h5B8D44);
      chk(ttg, 23'h4);
      from_blk = 1'h1;
      blk = 16'h2;
      cyc(4);
      chk(mi, 23'h78);
      chk(ttg, 23'h78);
      blk = 16'hFFFF;
      cyc(4);
      chk(mi, 23'h92784);
      from_blk = 1'h0;
      mi_h = 14'h3FFF;
      mi_m = 6'h3F;
      cyc(4);
      chk(mi, 23'h927BF);
      chk(ttg, 23'h927BF);
      complete_run;
   end
endmodule
